// File: occ_clock_control.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - reset selects the internal oscillator as clock
// - eight-bit calibration, reset value from fuses
// - control bit 7 enables the internal oscillator
// - read-only bit 6 flags oscillator ready
// - field bits 1-0 divide by 8/4/2/1
// - clock from external, undivided or divided internal
// - select bit 0 chooses internal or external
module occ_clock_control (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // factory calibration value captured after reset
  input wire logic [7:0] factory_cal,
  // special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // external oscillator clock edges, asynchronous
  input wire logic ext_osc_clock,
  // system clock enable and status
  output logic system_clock,
  output logic system_clock_external,
  output logic internal_osc_run,
  output logic [7:0] internal_osc_trim
);
  import occ_pkg::*;

  logic internal_osc_enable;
  logic [1:0] internal_clock_divider_field;
  logic [7:0] internal_osc_calibration;
  logic clock_source_select_bit;
  logic active_external;
  logic cal_loaded;
  logic [7:0] settle_count;
  logic internal_osc_ready_flag;
  logic [OCC_SYNC_STAGES-1:0] ext_sync;
  logic ext_prev;
  logic ext_edge;
  logic sel_control;
  logic sel_calibration;
  logic sel_select;
  logic [7:0] control_value;
  logic [7:0] next_rdata;
  logic next_system_clock;
  logic internal_tick;
  logic internal_tick_prev;
  logic internal_full_rate;
  logic switch_ok;
  logic wr_control;
  logic wr_calibration;
  logic wr_select;

  occ_div_if div_bus ();

  occ_divider u_divider (
    .clk(clk),
    .rst(rst),
    .bus(div_bus)
  );

  assign div_bus.div_sel = internal_clock_divider_field;
  assign div_bus.osc_run = internal_osc_enable && internal_osc_ready_flag;
  assign internal_tick = div_bus.tick;

  // one compare shared by the write enables and the read mux
  function automatic logic occ_addr_hit(input logic [7:0] addr, input logic [7:0] target);
    occ_addr_hit = (addr == target);
  endfunction

  // address decode
  assign sel_control = occ_addr_hit(sfr_addr, OCC_ADDR_CONTROL);
  assign sel_calibration = occ_addr_hit(sfr_addr, OCC_ADDR_CALIBRATION);
  assign sel_select = occ_addr_hit(sfr_addr, OCC_ADDR_SELECT);
  assign wr_control = sfr_wr && sel_control;
  assign wr_calibration = sfr_wr && sel_calibration;
  assign wr_select = sfr_wr && sel_select;

  // reserved bits 5-2 read as zero
  assign control_value = {internal_osc_enable, internal_osc_ready_flag, 4'h0,
                          internal_clock_divider_field};
  assign next_rdata = sel_control ? control_value :
                      sel_calibration ? internal_osc_calibration :
                      sel_select ? {7'h00, clock_source_select_bit} : 8'h00;

  // the external edge is only looked at after the two-stage synchroniser
  assign ext_edge = ext_sync[OCC_SYNC_STAGES-1] && !ext_prev;

  assign internal_full_rate = internal_tick && internal_tick_prev;
  // at 1/1 every cycle carries an internal pulse, so waiting for a gap would hang
  assign switch_ok = !ext_edge && (!internal_tick || internal_full_rate);

  // the mux follows the registered source, which only moves when switch_ok allows
  assign next_system_clock = active_external ? ext_edge : internal_tick;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      internal_osc_enable <= OCC_CONTROL_RESET[OCC_ENABLE_BIT];
      internal_clock_divider_field <= OCC_CONTROL_RESET[1:0];
    end else if (wr_control) begin
      internal_osc_enable <= sfr_wdata[OCC_ENABLE_BIT];
      internal_clock_divider_field <= sfr_wdata[OCC_DIV_LSB +: 2];
    end
  end

  // the fuse value is a port, so it is loaded by a clocked step after release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_loaded <= 1'b0;
      internal_osc_calibration <= 8'h00;
    end else if (!cal_loaded) begin
      cal_loaded <= 1'b1;
      internal_osc_calibration <= factory_cal;
    end else if (wr_calibration) begin
      internal_osc_calibration <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_source_select_bit <= OCC_SELECT_RESET;
    end else if (wr_select) begin
      clock_source_select_bit <= sfr_wdata[OCC_SELECT_BIT];
    end
  end

  // ready goes low while disabled or while a new trim settles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_count <= 8'h00;
      internal_osc_ready_flag <= 1'b0;
    end else if (!internal_osc_enable || !cal_loaded ||
                 wr_calibration) begin
      settle_count <= 8'h00;
      internal_osc_ready_flag <= 1'b0;
    end else if (settle_count < 8'(OCC_SETTLE_CYCLES)) begin
      settle_count <= settle_count + 8'h01;
    end else begin
      internal_osc_ready_flag <= 1'b1;
    end
  end

  // only the last stage leaves the synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_sync <= '0;
    end else begin
      ext_sync <= {ext_sync[OCC_SYNC_STAGES-2:0], ext_osc_clock};
    end
  end

  // reset low matches the idle pin, so no false edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_sync[OCC_SYNC_STAGES-1];
    end
  end

  // two ticks in a row mean the prescaler runs at 1/1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      internal_tick_prev <= 1'b0;
    end else begin
      internal_tick_prev <= internal_tick;
    end
  end

  // the select is adopted only between pulses, or at 1/1 on any cycle without an external edge, so no pulse is cut short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_external <= 1'b0;
    end else if (switch_ok) begin
      active_external <= clock_source_select_bit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      system_clock <= 1'b0;
    end else begin
      system_clock <= next_system_clock;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      system_clock_external <= 1'b0;
    end else begin
      system_clock_external <= active_external;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      internal_osc_run <= 1'b0;
    end else begin
      internal_osc_run <= internal_osc_enable;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      internal_osc_trim <= 8'h00;
    end else begin
      internal_osc_trim <= internal_osc_calibration;
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// File: occ_clock_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module occ_clock_control_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // clocks and status
  input wire logic ext_osc_clock,
  input wire logic system_clock,
  input wire logic system_clock_external,
  input wire logic internal_osc_run,
  input wire logic [7:0] internal_osc_trim
);
  import occ_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [1:0] div;
  logic [4:0] quiet;
  wire logic ctl_wr = sfr_wr && sfr_addr == OCC_ADDR_CONTROL;
  wire logic ctl_rd = sfr_rd && sfr_addr == OCC_ADDR_CONTROL;
  wire logic cal_wr = sfr_wr && sfr_addr == OCC_ADDR_CALIBRATION;
  // quiet saturates so ratio checks skip the adoption window after any write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= OCC_DIV8;
      quiet <= 5'h0;
    end else begin
      div <= ctl_wr ? sfr_wdata[1:0] : div;
      quiet <= sfr_wr ? 5'h0 : quiet + {4'h0, quiet != 5'h1f};
    end
  end
  property p_run;
    ctl_wr |=> ##1 internal_osc_run == $past(sfr_wdata[OCC_ENABLE_BIT], 2);
  endproperty
  a_run: assert property (p_run) else $error("enable bit not applied");
  property p_trim; cal_wr |=> ##1 internal_osc_trim == $past(sfr_wdata, 2); endproperty
  a_trim: assert property (p_trim) else $error("trim not updated");
  property p_rsvd; ctl_rd |=> sfr_rdata[5:2] == 4'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
  property p_rdy; ctl_rd && !internal_osc_run && quiet > 5'h2 |=> sfr_rdata[7:6] == 2'h0; endproperty
  a_rdy: assert property (p_rdy) else $error("ready while stopped");
  property p_off; (!internal_osc_run && !system_clock_external)[*4] |-> !system_clock; endproperty
  a_off: assert property (p_off) else $error("tick while stopped");
  property p_div8; system_clock && !system_clock_external && div == OCC_DIV8 && quiet == 5'h1f
    |=> !system_clock[*7]; endproperty
  a_div8: assert property (p_div8) else $error("short divided period");
  property p_div1; system_clock && !system_clock_external && div == OCC_DIV1 && quiet == 5'h1f
    |=> system_clock; endproperty
  a_div1: assert property (p_div1) else $error("undivided tick missing");
  property p_ext; system_clock_external && $rose(ext_osc_clock) |-> ##[2:4] system_clock; endproperty
  a_ext: assert property (p_ext) else $error("external tick missing");
  c_ext: cover property (system_clock && system_clock_external);
  c_div1: cover property (system_clock && div == OCC_DIV1);
  c_rd: cover property (ctl_rd);
endmodule
`default_nettype wire

// File: occ_div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface occ_div_if;
  logic [1:0] div_sel;
  logic osc_run;
  logic tick;
  modport ctrl (output div_sel, output osc_run, input tick);
  modport div (input div_sel, input osc_run, output tick);
endinterface
`default_nettype wire

// File: occ_divider.sv
`timescale 1ns/1ps
`default_nettype none
// prescaler: one-cycle tick at 1/1, 1/2, 1/4 or 1/8 of the oscillator rate
module occ_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control side
  occ_div_if.div bus
);
  import occ_pkg::*;
  logic [2:0] count;
  logic [1:0] active_sel;
  logic wrap;
  logic [2:0] limit;
  assign limit = (active_sel == OCC_DIV8) ? 3'h7 :
                 (active_sel == OCC_DIV4) ? 3'h3 :
                 (active_sel == OCC_DIV2) ? 3'h1 : 3'h0;
  assign wrap = (count >= limit);
  // the new ratio is only adopted at a period boundary, so no short period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 3'h0;
      active_sel <= OCC_DIV8;
      bus.tick <= 1'b0;
    end else if (!bus.osc_run) begin
      count <= 3'h0;
      bus.tick <= 1'b0;
    end else begin
      count <= wrap ? 3'h0 : count + 3'h1;
      if (wrap) begin
        active_sel <= bus.div_sel;
      end
      bus.tick <= wrap;
    end
  end
endmodule
`default_nettype wire

// File: occ_pkg.sv
package occ_pkg;
  // register addresses on the core's special-function register bus
  localparam logic [7:0] OCC_ADDR_CONTROL = 8'h8a;
  localparam logic [7:0] OCC_ADDR_CALIBRATION = 8'h8b;
  localparam logic [7:0] OCC_ADDR_SELECT = 8'h8f;
  // field positions
  localparam int OCC_ENABLE_BIT = 7;
  localparam int OCC_READY_BIT = 6;
  localparam int OCC_DIV_LSB = 0;
  localparam int OCC_SELECT_BIT = 0;
  // reset values; the calibration reset value is supplied from fuses
  localparam logic [7:0] OCC_CONTROL_RESET = 8'hc0;
  localparam logic OCC_SELECT_RESET = 1'b0;
  // divider field encodings
  localparam logic [1:0] OCC_DIV8 = 2'h0;
  localparam logic [1:0] OCC_DIV4 = 2'h1;
  localparam logic [1:0] OCC_DIV2 = 2'h2;
  localparam logic [1:0] OCC_DIV1 = 2'h3;
  // oscillator settling after enable or a calibration change
  localparam int OCC_SETTLE_NS = 100;
  localparam int OCC_CLK_PERIOD_PS = 5000;
  localparam int OCC_SETTLE_CYCLES = (OCC_SETTLE_NS * 1000 + OCC_CLK_PERIOD_PS - 1)
                                     / OCC_CLK_PERIOD_PS;
  localparam int OCC_SYNC_STAGES = 2;
endpackage

// File: test_internal_oscillator_clock_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_internal_oscillator_clock_control;
  import occ_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, ext_osc_clock = 1'b0;
  logic [7:0] sfr_addr = 8'h0, sfr_wdata = 8'h0, sfr_rdata, internal_osc_trim;
  logic system_clock, system_clock_external, internal_osc_run;
  int errors = 0, total_checks = 0, n;
  occ_clock_control u_dut (.clk(clk), .rst(rst), .factory_cal(8'h5a), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .ext_osc_clock(ext_osc_clock), .system_clock(system_clock),
    .system_clock_external(system_clock_external), .internal_osc_run(internal_osc_run),
    .internal_osc_trim(internal_osc_trim));
  initial forever #2.5 clk = ~clk;
  // external oscillator at one eighth of clk
  initial forever begin
    repeat (4) @(posedge clk);
    ext_osc_clock <= ~ext_osc_clock;
  end
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 chk("sfr_rdata", e, sfr_rdata);
  endtask
  task ticks(input int len, input logic [7:0] e);
    n = 0;
    repeat (len) begin
      @(posedge clk);
      #1 if (system_clock === 1'b1) n++;
    end
    chk("ticks", e, 8'(n));
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    rd(OCC_ADDR_CONTROL, OCC_CONTROL_RESET);
    rd(OCC_ADDR_SELECT, 8'h00);
    rd(OCC_ADDR_CALIBRATION, 8'h5a);
    chk("internal_osc_trim", 8'h5a, internal_osc_trim);
    for (int d = 0; d < 4; d++) begin
      wr(OCC_ADDR_CONTROL, 8'hbc | 8'(d));
      repeat (24) @(posedge clk);
      rd(OCC_ADDR_CONTROL, 8'hc0 | 8'(d));
      ticks(64, 8'h08 << d);
    end
    wr(OCC_ADDR_CONTROL, 8'h03);
    rd(OCC_ADDR_CONTROL, 8'h03);
    ticks(32, 8'h00);
    rd(OCC_ADDR_CONTROL, 8'h03);
    wr(OCC_ADDR_CALIBRATION, 8'h40);
    wr(OCC_ADDR_CONTROL, 8'h83);
    rd(OCC_ADDR_CONTROL, 8'h83);
    repeat (24) @(posedge clk);
    rd(OCC_ADDR_CALIBRATION, 8'h40);
    chk("internal_osc_trim", 8'h40, internal_osc_trim);
    wr(OCC_ADDR_SELECT, 8'h01);
    repeat (16) @(posedge clk);
    rd(OCC_ADDR_SELECT, 8'h01);
    chk("system_clock_external", 8'h01, {7'h0, system_clock_external});
    ticks(64, 8'h08);
    wr(OCC_ADDR_SELECT, 8'h00);
    repeat (16) @(posedge clk);
    ticks(16, 8'h10);
    rd(8'h55, 8'h00);
    summarize;
  end
endmodule
bind occ_clock_control occ_clock_control_chk u_chk (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .ext_osc_clock(ext_osc_clock), .system_clock(system_clock),
  .system_clock_external(system_clock_external), .internal_osc_run(internal_osc_run),
  .internal_osc_trim(internal_osc_trim));
`default_nettype wire
